// ==== rtl/bps_host.sv ====
/*
  Host-side sequencer that programs one byte of a parallel flash per request
  through set-up, program, timed pulse, verify, margin read and reset writes.
  Assumes the flash pins are synchronous to core_clk_in and that an external
  switch ramps the programming supply and reports when the ramp is done.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bps_defs.svh"

module bps_host
  import bps_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // User request
  input wire logic start_in,
  input wire bps_req_t req_in,
  output logic busy_out,
  output logic done_out,
  output logic fail_out,
  output logic [4:0] pulses_out,
  // System interrupt pending
  input wire logic irq_in,
  // Programming supply
  output logic prog_supply_high_out,
  input wire logic supply_ramped_in,
  // Flash pins
  output bps_bus_t flash_out,
  input wire logic [7:0] flash_dq_in
);

  localparam int PULSE_END = `BPS_PULSE_CYC - 1;
  localparam int RECOV_END = `BPS_RECOV_CYC - 1;

  bps_state_t st_q, st_d;
  logic [9:0] cyc_q, cyc_d;
  logic [4:0] cnt_q, cnt_d;
  bps_req_t req_q, req_d;
  logic [7:0] rd_q, rd_d;
  logic fail_q, fail_d;
  logic done_q, done_d;
  logic vpp_q, vpp_d;
  bps_bus_t bus_q, bus_d;

  function automatic logic is_write(input bps_state_t s);
    is_write = (s == S_WR_SETUP) || (s == S_WR_PROG) || (s == S_WR_VERIFY) ||
               (s == S_WR_RESET1) || (s == S_WR_RESET2);
  endfunction

  function automatic logic [7:0] wr_data(input bps_state_t s, input logic [7:0] d);
    case (s)
      S_WR_SETUP: wr_data = `BPS_CMD_SETUP;
      S_WR_PROG: wr_data = d;
      S_WR_VERIFY: wr_data = `BPS_CMD_VERIFY;
      default: wr_data = `BPS_CMD_RESET;
    endcase
  endfunction

  always_comb begin
    st_d = st_q;
    cyc_d = cyc_q + 10'h001;
    cnt_d = cnt_q;
    req_d = req_q;
    rd_d = rd_q;
    fail_d = fail_q;
    done_d = 1'b0;
    vpp_d = vpp_q;
    case (st_q)
      S_IDLE: begin
        cyc_d = 10'h000;
        if (start_in) begin
          req_d = req_in;
          cnt_d = 5'h00;
          fail_d = 1'b0;
          vpp_d = 1'b1;
          st_d = S_VPP_ON;
        end
      end
      S_VPP_ON: begin
        cyc_d = 10'h000;
        if (supply_ramped_in) begin
          st_d = S_SETTLE;
        end
      end
      S_SETTLE: begin
        // Supply must be stable before the first command write
        if (cyc_q == 10'(`BPS_SETTLE_CYC - 1)) begin
          cyc_d = 10'h000;
          st_d = S_WR_SETUP;
        end
      end
      S_PULSE: begin
        // Pulse always ends in a verify write, early on an interrupt
        if (cyc_q == 10'(PULSE_END) || irq_in) begin
          cyc_d = 10'h000;
          st_d = S_WR_VERIFY;
        end
      end
      S_RECOVER: begin
        if (cyc_q == 10'(RECOV_END)) begin
          cyc_d = 10'h000;
          st_d = S_READ;
        end
      end
      S_READ: begin
        if (cyc_q == `BPS_RD_END) begin
          rd_d = flash_dq_in;
          cyc_d = 10'h000;
          st_d = S_COMPARE;
        end
      end
      S_COMPARE: begin
        cyc_d = 10'h000;
        // Compare against kept data; retry or give up at the limit
        if (rd_q == req_q.data) begin
          st_d = S_WR_RESET1;
        end else if (cnt_q == `BPS_MAX_PULSES) begin
          fail_d = 1'b1;
          st_d = S_WR_RESET1;
        end else begin
          st_d = S_WR_SETUP;
        end
      end
      S_FINISH: begin
        cyc_d = 10'h000;
        vpp_d = 1'b0;
        done_d = 1'b1;
        st_d = S_IDLE;
      end
      default: begin
        if (is_write(st_q) && cyc_q == `BPS_WR_END) begin
          cyc_d = 10'h000;
          case (st_q)
            S_WR_SETUP: st_d = S_WR_PROG;
            S_WR_PROG: begin
              cnt_d = cnt_q + 5'h01;
              st_d = S_PULSE;
            end
            S_WR_VERIFY: st_d = S_RECOVER;
            S_WR_RESET1: st_d = S_WR_RESET2;
            default: st_d = S_FINISH;
          endcase
        end else if (!is_write(st_q)) begin
          st_d = S_IDLE;
        end
      end
    endcase
  end

  // Pins follow the next state so the strobes come straight from flip-flops
  always_comb begin
    bus_d.addr = req_d.addr;
    bus_d.dq = wr_data(st_d, req_d.data);
    bus_d.dq_oe_n = !is_write(st_d);
    bus_d.we_n = !(is_write(st_d) && cyc_d >= `BPS_WE_FIRST && cyc_d <= `BPS_WE_LAST);
    bus_d.oe_n = (st_d != S_READ);
    bus_d.ce_n = !(is_write(st_d) || st_d == S_READ);
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= S_IDLE;
      cyc_q <= 10'h000;
      cnt_q <= 5'h00;
      req_q <= '0;
      rd_q <= 8'h00;
      fail_q <= 1'b0;
      done_q <= 1'b0;
      vpp_q <= 1'b0;
      bus_q <= {15'h0000, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1};
    end else begin
      st_q <= st_d;
      cyc_q <= cyc_d;
      cnt_q <= cnt_d;
      req_q <= req_d;
      rd_q <= rd_d;
      fail_q <= fail_d;
      done_q <= done_d;
      vpp_q <= vpp_d;
      bus_q <= bus_d;
    end
  end

  assign flash_out = bus_q;
  assign busy_out = (st_q != S_IDLE);
  assign done_out = done_q;
  assign fail_out = fail_q;
  assign pulses_out = cnt_q;
  assign prog_supply_high_out = vpp_q;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_pulse_end;
    (st_q == S_PULSE) ##1 (st_q == S_WR_VERIFY);
  endsequence

  property p_setup_code;
    (st_q == S_WR_SETUP && !flash_out.we_n) |-> (flash_out.dq == `BPS_CMD_SETUP);
  endproperty
  a_setup_code: assert property (p_setup_code) else $error("set-up code wrong");

  property p_prog_after_setup;
    $rose(st_q == S_WR_PROG) |-> $past(st_q) == S_WR_SETUP;
  endproperty
  a_prog_after_setup: assert property (p_prog_after_setup) else $error("program w/o set-up");

  property p_verify_code;
    (st_q == S_WR_VERIFY && !flash_out.we_n) |-> (flash_out.dq == `BPS_CMD_VERIFY);
  endproperty
  a_verify_code: assert property (p_verify_code) else $error("verify code wrong");

  property p_pulse_len;
    (st_q == S_PULSE && st_d != S_PULSE && !irq_in) |-> (cyc_q == 10'(PULSE_END));
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");

  property p_pulse_ends_verify;
    $fell(st_q == S_PULSE) |-> $past(st_q == S_PULSE) ##0 (st_q == S_WR_VERIFY);
  endproperty
  a_pulse_ends_verify: assert property (p_pulse_ends_verify) else $error("no verify");

  property p_irq_stop;
    (st_q == S_PULSE && irq_in) |-> s_pulse_end;
  endproperty
  a_irq_stop: assert property (p_irq_stop) else $error("interrupt not honoured");

  property p_recovery;
    (st_q == S_RECOVER && st_d == S_READ) |-> (cyc_q == 10'(RECOV_END));
  endproperty
  a_recovery: assert property (p_recovery) else $error("read before recovery");

  property p_limit;
    (cnt_q <= `BPS_MAX_PULSES) and ((st_q == S_COMPARE && fail_d) |-> cnt_q == `BPS_MAX_PULSES);
  endproperty
  a_limit: assert property (p_limit) else $error("pulse limit broken");

  property p_settled;
    $rose(st_q == S_WR_SETUP) && $past(st_q) == S_SETTLE |->
      vpp_q && ($past(cyc_q) == 10'(`BPS_SETTLE_CYC - 1));
  endproperty
  a_settled: assert property (p_settled) else $error("command before supply");

  property p_reset_twice;
    (st_q == S_WR_RESET1 && st_d == S_WR_RESET2) |=> (st_q == S_WR_RESET2) [*6] ##1 st_q == S_FINISH;
  endproperty
  a_reset_twice: assert property (p_reset_twice) else $error("reset pair broken");

endmodule

`default_nettype wire

// ==== rtl/bps_defs.svh ====
/*
  Timing counts, command codes and limits for the byte program sequencer.
  Assumes a 100 MHz core clock; pulse, recovery and settle counts are derived from a time in ns.
*/
// Overview of operation
// - Host always ends programming with verify command
// - Host compares; mismatch repeats whole attempt
// - Host times 10 us programming pulse
// - At most 25 attempts per byte
// - Host waits 6 us before verify read
// - FFH write returns device to read
// - Supply settled 100 ns before commands
// - Interrupt mid-pulse forces early verify command
// - Abort from set-up needs reset twice
`ifndef BPS_DEFS_SVH
`define BPS_DEFS_SVH

`define BPS_CLK_NS 10
`define BPS_CMD_SETUP 8'h40
`define BPS_CMD_VERIFY 8'hc0
`define BPS_CMD_RESET 8'hff
`define BPS_MAX_PULSES 5'h19
`define BPS_PULSE_NS 10000
`define BPS_RECOV_NS 6000
`define BPS_SETTLE_NS 100
`define BPS_PULSE_CYC ((`BPS_PULSE_NS + `BPS_CLK_NS - 1) / `BPS_CLK_NS)
`define BPS_RECOV_CYC ((`BPS_RECOV_NS + `BPS_CLK_NS - 1) / `BPS_CLK_NS)
`define BPS_SETTLE_CYC ((`BPS_SETTLE_NS + `BPS_CLK_NS - 1) / `BPS_CLK_NS)
`define BPS_WE_FIRST 10'h001
`define BPS_WE_LAST 10'h004
`define BPS_WR_END 10'h005
`define BPS_RD_END 10'h007

`endif

// ==== rtl/bps_pkg.sv ====
/*
  Types of the byte program sequencer: request, flash pin bundle, states.
  Assumes a 32K x 8 parallel flash on the far side of the pins.
*/
package bps_pkg;

  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] data;
  } bps_req_t;

  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] dq;
    logic dq_oe_n;
    logic we_n;
    logic oe_n;
    logic ce_n;
  } bps_bus_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_VPP_ON = 4'h1,
    S_SETTLE = 4'h2,
    S_WR_SETUP = 4'h3,
    S_WR_PROG = 4'h4,
    S_PULSE = 4'h5,
    S_WR_VERIFY = 4'h6,
    S_RECOVER = 4'h7,
    S_READ = 4'h8,
    S_COMPARE = 4'h9,
    S_WR_RESET1 = 4'ha,
    S_WR_RESET2 = 4'hb,
    S_FINISH = 4'hc
  } bps_state_t;

endpackage

// ==== sim/bps_flash_model.sv ====
/*
  Behavioural flash device that answers the host's command writes.
  Assumes the host pins and a supply-present level come from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module bps_flash_model
  import bps_pkg::*;
(
  // Host pins and supply
  input wire bps_bus_t bus_in,
  input wire logic supply_in,
  // Test controls
  input wire logic clr_in,
  input wire logic [5:0] need_in,
  // Read data
  output logic [7:0] dq_out
);
  typedef enum logic [1:0] {M_READ, M_SETUP, M_PROG, M_VERIFY} bps_mode_t;
  bps_mode_t mode_q = M_READ;
  logic [7:0] mem_q [0:32767] = '{default: 8'hff};
  logic [14:0] addr_q = 15'h0000;
  logic [7:0] pdata_q = 8'hff;
  logic [7:0] last_q = 8'h00;
  int cnt_q = 0;
  time t_pulse = 0;
  time t_ver = 0;
  time pulse_ns = 0;
  time eff_ns = 0;
  time recov_ns = 0;
  always @(negedge bus_in.we_n) begin
    if (!bus_in.ce_n && mode_q == M_SETUP) addr_q = bus_in.addr;
  end
  always @(negedge bus_in.oe_n) begin
    if (mode_q == M_VERIFY) recov_ns = $time - t_ver;
  end
  always @(posedge bus_in.oe_n) last_q = mem_q[addr_q];
  always @(posedge bus_in.we_n or posedge clr_in) begin
    if (clr_in) begin
      cnt_q = 0;
    end else if (!bus_in.ce_n) begin
      case (mode_q)
        // A reset here is taken as null program data
        M_SETUP: begin
          pdata_q = bus_in.dq;
          t_pulse = $time;
          mode_q = M_PROG;
        end
        M_PROG: begin
          if (bus_in.dq == 8'hc0) begin
            pulse_ns = $time - t_pulse;
            eff_ns = (pulse_ns > 10000) ? 10000 : pulse_ns;
            t_ver = $time;
            cnt_q = cnt_q + 1;
            // A pulse of no length programs nothing
            if (supply_in && eff_ns > 0 && cnt_q >= need_in) begin
              mem_q[addr_q] = mem_q[addr_q] & pdata_q;
            end
            mode_q = M_VERIFY;
          end else begin
            mode_q = M_READ;
          end
        end
        default: mode_q = (bus_in.dq == 8'h40) ? M_SETUP : M_READ;
      endcase
    end
  end
  // Released bus shows the inverse of mem_q at addr_q, taken when oe_n rises
  assign dq_out = (!bus_in.oe_n && !bus_in.ce_n) ?
    mem_q[(mode_q == M_VERIFY) ? addr_q : bus_in.addr] : ~last_q;
endmodule
`default_nettype wire

// ==== sim/bps_host_bench.sv ====
/*
  Self-checking bench of the byte program sequencer against the flash model.
  Assumes the supply switch reports its ramp 20 cycles after prog_supply_high_out is seen high.
*/
`timescale 1ns/100ps
`default_nettype none
module bps_host_bench;
  import bps_pkg::*;
  logic core_clk_in;
  logic rstn_in;
  logic start_in;
  logic irq_in;
  logic supply_ramped_in;
  logic clr;
  logic [5:0] need;
  bps_req_t req_in;
  logic busy_out;
  logic done_out;
  logic fail_out;
  logic [4:0] pulses_out;
  logic prog_supply_high_out;
  bps_bus_t flash_out;
  logic [7:0] flash_dq;
  int mismatches = 0;
  int samples_checked = 0;
  time settle_ns = 0;

  bps_host dut_u (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .start_in(start_in),
    .req_in(req_in), .busy_out(busy_out), .done_out(done_out), .fail_out(fail_out),
    .pulses_out(pulses_out), .irq_in(irq_in), .prog_supply_high_out(prog_supply_high_out),
    .supply_ramped_in(supply_ramped_in), .flash_out(flash_out), .flash_dq_in(flash_dq));
  bps_flash_model mod_u (.bus_in(flash_out), .supply_in(prog_supply_high_out & supply_ramped_in),
    .clr_in(clr), .need_in(need), .dq_out(flash_dq));

  task automatic chk_eq(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("ERROR %s expected %0h seen %0h", n, e, g);
      mismatches++;
    end
  endtask
  task automatic chk_min(input string n, input time lo, input time g);
    samples_checked++;
    if ($isunknown(g) || g < lo) begin
      $display("ERROR %s expected at least %0d seen %0d", n, lo, g);
      mismatches++;
    end
  endtask
  task automatic timed_out(input string n);
    $display("ERROR %s expected event seen timeout", n);
    mismatches++;
    give_verdict();
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One request; the model needs n pulses; irq raised c cycles into the pulse
  task automatic run_req(input logic [14:0] a, input logic [7:0] d, input logic [5:0] n,
    input int c);
    int i;
    time t0;
    need = n;
    clr = 1;
    repeat (3) @(negedge core_clk_in);
    clr = 0;
    start_in = 1;
    req_in = {a, d};
    @(negedge core_clk_in);
    start_in = 0;
    chk_eq("busy_out", 1, busy_out);
    for (i = 0; i < 100 && prog_supply_high_out !== 1; i++) @(negedge core_clk_in);
    if (prog_supply_high_out !== 1) timed_out("prog_supply_high_out");
    repeat (20) @(negedge core_clk_in);
    supply_ramped_in = 1;
    t0 = $time;
    for (i = 0; i < 100 && flash_out.we_n !== 0; i++) @(negedge core_clk_in);
    if (flash_out.we_n !== 0) timed_out("flash_out.we_n");
    settle_ns = $time - t0;
    if (c > 0) begin
      for (i = 0; i < 200 && mod_u.mode_q != 2; i++) @(negedge core_clk_in);
      if (mod_u.mode_q != 2) timed_out("model program mode");
      repeat (c) @(negedge core_clk_in);
      irq_in = 1;
      @(negedge core_clk_in);
      irq_in = 0;
    end
    for (i = 0; i < 60000 && done_out !== 1; i++) @(negedge core_clk_in);
    supply_ramped_in = 0;
    if (done_out !== 1) timed_out("done_out");
    chk_eq("busy_out", 0, busy_out);
    chk_eq("prog_supply_high_out", 0, prog_supply_high_out);
  endtask
  task automatic test_single;
    run_req(15'h1234, 8'h5a, 6'd1, 0);
    chk_eq("fail_out", 0, fail_out);
    chk_eq("pulses_out", 1, pulses_out);
    chk_eq("byte", 8'h5a, mod_u.mem_q[15'h1234]);
    chk_min("pulse_ns", 10000, mod_u.pulse_ns);
    chk_min("recov_ns", 6000, mod_u.recov_ns);
    chk_min("settle_ns", 100, settle_ns);
    chk_eq("mode", 0, mod_u.mode_q);
    $display("test_single done");
  endtask
  task automatic test_retry;
    run_req(15'h7fff, 8'h00, 6'd3, 0);
    chk_eq("pulses_out", 3, pulses_out);
    chk_eq("byte", 8'h00, mod_u.mem_q[15'h7fff]);
    chk_eq("fail_out", 0, fail_out);
    chk_min("recov_ns", 6000, mod_u.recov_ns);
    $display("test_retry done");
  endtask
  task automatic test_limit;
    run_req(15'h0000, 8'h3c, 6'd40, 0);
    chk_eq("fail_out", 1, fail_out);
    chk_eq("pulses_out", 5'h19, pulses_out);
    chk_eq("byte", 8'hff, mod_u.mem_q[15'h0000]);
    chk_eq("mode", 0, mod_u.mode_q);
    $display("test_limit done");
  endtask
  task automatic test_irq;
    run_req(15'h0a5a, 8'h81, 6'd1, 300);
    chk_eq("pulse_cut", 1, mod_u.pulse_ns < 10000);
    chk_eq("byte", 8'h81, mod_u.mem_q[15'h0a5a]);
    chk_eq("pulses_out", 1, pulses_out);
    $display("test_irq done");
  endtask

  initial begin
    core_clk_in = 0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  initial begin
    rstn_in = 0;
    start_in = 0;
    irq_in = 0;
    supply_ramped_in = 0;
    clr = 0;
    need = 6'h01;
    req_in = '0;
    repeat (10) @(negedge core_clk_in);
    rstn_in = 1;
    test_single();
    test_retry();
    test_limit();
    test_irq();
    give_verdict();
  end
endmodule
`default_nettype wire
